// ---- hdl/uart_scb_regs.vh ----
// Register map, field positions and timing constants of the serial control bank
`ifndef UART_SCB_REGS_VH
`define UART_SCB_REGS_VH

`define ADDR_MODE 16'h0220
`define ADDR_STAT 16'h0222
`define ADDR_TXD 16'h0224
`define ADDR_RXD 16'h0226
`define ADDR_BRG 16'h0228

`define MODE_RESET 16'h0000
`define STAT_RESET 16'h0110
`define BRG_RESET 16'h0000
`define MODE_WMASK 16'hB4FF

`define MODE_IR_BIT 12
`define MODE_FMT_HI 2
`define MODE_FMT_LO 1
`define MODE_STOP_BIT 0

`define STAT_TXI_HI 15
`define STAT_TXPOL 14
`define STAT_TXI_LO 13
`define STAT_BRK 11
`define STAT_TXEN 10
`define STAT_TXFULL 9
`define STAT_TXEMPTY 8
`define STAT_RXI_HI 7
`define STAT_RXI_LO 6
`define STAT_ADDR_DET 5
`define STAT_RXIDLE 4
`define STAT_PARITY_ERROR_FLAG 3
`define STAT_FRAMING_ERROR_FLAG 2
`define STAT_OVERRUN 1
`define STAT_RXAVAIL 0

`define FMT_NINE 2'b11
`define FMT_ODD 2'b10
`define FMT_EVEN 2'b01
`define TXI_EACH 2'b00
`define TXI_DONE 2'b01
`define TXI_EMPTY 2'b10
`define RXI_FULL 2'b11
`define RXI_THREE 2'b10

`define SUB_LAST 4'hF
`define SUB_MID 4'h7
`define IR_PULSE 4'h3
`define BREAK_LAST 4'hB
`define RX_THREE 3'h3

`endif

// ---- hdl/rx_char_store.v ----
// Small receive character memory with registered read port and write-through
`timescale 1ns/1ns
module rx_char_store #(
    parameter W = 11,
    parameter AW = 2
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Write side
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [W-1:0] wdata,
    // Read side
    input wire [AW-1:0] raddr,
    output reg [W-1:0] q
);
    reg [W-1:0] mem [0:(1<<AW)-1];

    always @(posedge core_clk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    // Write-through keeps the head visible in the cycle after a push into an empty store
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= {W{1'b0}};
        else if (we && waddr == raddr)
            q <= wdata;
        else
            q <= mem[raddr];
    end
endmodule // rx_char_store

// ---- hdl/uart_status_control_bank.v ----
// Serial transceiver control and status bank with transmit path and receive FIFO
//
// Behaviour
// - Format field 11 nine bits, 10 eight odd parity, 01 eight even, 00 eight.
// - Stop-select 1 sends two stop bits, 0 sends one.
// - Transmit mode 10 interrupts when a transfer leaves the buffer empty; 11 reserved.
// - Transmit mode 01 interrupts after the last character fully shifts out.
// - Transmit mode 00 interrupts on every buffer to shift register transfer.
// - Polarity bit sets encoded idle level, only when infrared codec enabled.
// - Break request sends start, twelve zeros, stop; hardware clears request after.
// - Clearing transmit enable aborts, empties buffer, releases pin; setting claims pin.
// - Buffer full flag reads 1 when no more characters can be queued.
// - Transmitter empty flag reads 1 only when shift register and buffer empty.
// - Receive mode 11 interrupts when a transfer brings buffer to four.
// - Receive mode 10 interrupts when a transfer brings buffer to three.
// - Receive mode 0x interrupts on every received character transfer.
// - Address detect keeps only ninth-bit-set characters, only in nine-bit format.
// - Receiver idle flag reads 1 idle, 0 while receiving.
// - Parity error flag belongs to the character at FIFO head.
// - Framing error flag belongs to the character at FIFO head.
// - Overflow sets overrun; software 1 to 0 clears it and flushes receiver.
// - Data available reads 1 while the receive FIFO holds a character.
// - Reading receive data pops FIFO; next head brings its own error flags.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`include "uart_scb_regs.vh"
module uart_status_control_bank #(
    parameter AW = 2
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Register port
    input wire [15:0] addr,
    input wire [15:0] wdata,
    input wire [1:0] wr_lanes,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    // Serial pins
    input wire serial_in_pin,
    output reg serial_out_pin,
    output reg serial_out_enable,
    // Interrupt events
    output reg tx_irq,
    output reg rx_irq
);
    localparam TX_IDLE = 3'h0;
    localparam TX_START = 3'h1;
    localparam TX_DATA = 3'h2;
    localparam TX_PAR = 3'h3;
    localparam TX_STOP = 3'h4;
    localparam TX_BRK = 3'h5;
    localparam RX_IDLE = 3'h0;
    localparam RX_START = 3'h1;
    localparam RX_DATA = 3'h2;
    localparam RX_PAR = 3'h3;
    localparam RX_STOP = 3'h4;
    localparam [AW:0] DEPTH = 1 << AW;

    reg [15:0] serial_mode_control;
    reg [15:0] bit_rate_divisor;
    reg [15:0] baud_cnt;
    reg tx_irq_mode_hi, tx_irq_mode_lo, tx_encoded_polarity, send_break_request;
    reg transmitter_enable, rx_irq_mode_hi, rx_irq_mode_lo, address_detect_enable;
    reg overrun_error_flag;
    reg [2:0] tx_state, rx_state;
    reg [3:0] tx_sub, tx_cnt, rx_sub, rx_cnt;
    reg [8:0] transmit_shift_register, hold_data, receive_shift_register;
    reg hold_valid, tx_par, break_active;
    reg rx_sync1, rx_in, rx_par, rx_parity_error_flag;
    reg [AW-1:0] wr_ptr, rd_ptr;
    reg [AW:0] count;
    wire [10:0] head;

    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input [1:0] lanes;
        begin
            merge = {lanes[1] ? nw[15:8] : old[15:8], lanes[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    wire [1:0] char_format_select = serial_mode_control[`MODE_FMT_HI:`MODE_FMT_LO];
    wire stop_count_select = serial_mode_control[`MODE_STOP_BIT];
    wire infrared_codec_enable = serial_mode_control[`MODE_IR_BIT];
    wire nine_bit = (char_format_select == `FMT_NINE);
    wire parity_on = (char_format_select == `FMT_ODD) || (char_format_select == `FMT_EVEN);
    wire [3:0] last_data = nine_bit ? 4'h8 : 4'h7;
    wire [1:0] tx_mode = {tx_irq_mode_hi, tx_irq_mode_lo};
    wire [1:0] rx_mode = {rx_irq_mode_hi, rx_irq_mode_lo};
    wire tick = (baud_cnt == bit_rate_divisor);
    wire wr_mode = wr && addr == `ADDR_MODE;
    wire wr_stat = wr && addr == `ADDR_STAT;
    wire wr_txd = wr && addr == `ADDR_TXD;
    wire wr_brg = wr && addr == `ADDR_BRG;
    wire [15:0] stat_new = merge(16'h0000, wdata, wr_lanes);
    wire tx_bit_end = tick && tx_sub == `SUB_LAST;
    wire tx_load = transmitter_enable && tx_state == TX_IDLE && hold_valid;
    wire tx_finish = tx_bit_end && tx_state == TX_STOP && !(stop_count_select && tx_cnt == 4'h0);
    wire transmitter_empty = !hold_valid && tx_state == TX_IDLE;
    wire receiver_idle_flag = (rx_state == RX_IDLE);
    wire rx_sample = tick && rx_sub == `SUB_MID;
    wire rx_done = rx_sample && rx_state == RX_STOP;
    wire [8:0] rx_char = nine_bit ? receive_shift_register : {1'b0, receive_shift_register[8:1]};
    wire rx_keep = !(address_detect_enable && nine_bit && !rx_char[8]);
    wire push = rx_done && rx_keep && count != DEPTH;
    wire overflow = rx_done && rx_keep && count == DEPTH;
    wire flush = wr_stat && wr_lanes[0] && overrun_error_flag && !stat_new[`STAT_OVERRUN]
        && !overflow;
    wire pop = rd && addr == `ADDR_RXD && count != {(AW+1){1'b0}};
    wire [AW-1:0] next_rd_ptr = pop ? rd_ptr + {{(AW-1){1'b0}}, 1'b1} : rd_ptr;
    wire [AW:0] count_after = count + {{AW{1'b0}}, 1'b1};
    wire parity_expect = (char_format_select == `FMT_ODD) ? ~^rx_char[7:0] : ^rx_char[7:0];

    rx_char_store #(
        .W(11),
        .AW(AW)
    ) u_store (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .we(push),
        .waddr(wr_ptr),
        .wdata({rx_parity_error_flag, !rx_in, rx_char}),
        .raddr(flush ? {AW{1'b0}} : next_rd_ptr),
        .q(head)
    );

    // Control fields; a break done by hardware loses to a set written in the same cycle
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serial_mode_control <= `MODE_RESET;
            bit_rate_divisor <= `BRG_RESET;
            tx_irq_mode_hi <= 1'b0;
            tx_irq_mode_lo <= 1'b0;
            tx_encoded_polarity <= 1'b0;
            send_break_request <= 1'b0;
            transmitter_enable <= 1'b0;
            rx_irq_mode_hi <= 1'b0;
            rx_irq_mode_lo <= 1'b0;
            address_detect_enable <= 1'b0;
        end
        else
        begin
            if (wr_mode)
                serial_mode_control <= merge(serial_mode_control, wdata, wr_lanes) & `MODE_WMASK;
            if (wr_brg)
                bit_rate_divisor <= merge(bit_rate_divisor, wdata, wr_lanes);
            if (tx_finish && break_active)
                send_break_request <= 1'b0;
            if (wr_stat && wr_lanes[1])
            begin
                tx_irq_mode_hi <= wdata[`STAT_TXI_HI];
                tx_encoded_polarity <= wdata[`STAT_TXPOL];
                tx_irq_mode_lo <= wdata[`STAT_TXI_LO];
                transmitter_enable <= wdata[`STAT_TXEN];
                if (wdata[`STAT_BRK])
                    send_break_request <= 1'b1;
                else if (!(tx_finish && break_active))
                    send_break_request <= 1'b0;
            end
            if (wr_stat && wr_lanes[0])
            begin
                rx_irq_mode_hi <= wdata[`STAT_RXI_HI];
                rx_irq_mode_lo <= wdata[`STAT_RXI_LO];
                address_detect_enable <= wdata[`STAT_ADDR_DET];
            end
        end
    end

    // Shared 16x baud tick; rewriting the divisor restarts it so a new rate applies at once
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            baud_cnt <= 16'h0000;
        else if (wr_brg || tick)
            baud_cnt <= 16'h0000;
        else
            baud_cnt <= baud_cnt + 16'h0001;
    end

    // Transmit holding buffer and shifter
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_valid <= 1'b0;
            hold_data <= 9'h000;
            tx_state <= TX_IDLE;
            tx_sub <= 4'h0;
            tx_cnt <= 4'h0;
            transmit_shift_register <= 9'h000;
            tx_par <= 1'b0;
            break_active <= 1'b0;
        end
        else if (!transmitter_enable)
        begin
            tx_state <= TX_IDLE;
            tx_sub <= 4'h0;
            if (wr_stat && wr_lanes[1] && !wdata[`STAT_TXEN])
                hold_valid <= 1'b0;
            else if (wr_txd && !hold_valid)
            begin
                hold_valid <= 1'b1;
                hold_data <= {wr_lanes[1] & wdata[8], wdata[7:0]};
            end
        end
        else
        begin
            if (wr_stat && wr_lanes[1] && !wdata[`STAT_TXEN])
            begin
                hold_valid <= 1'b0;
                tx_state <= TX_IDLE;
            end
            else if (tx_load)
            begin
                hold_valid <= 1'b0;
                transmit_shift_register <= hold_data;
                tx_par <= (char_format_select == `FMT_ODD) ? ~^hold_data[7:0] : ^hold_data[7:0];
                break_active <= send_break_request;
                tx_state <= TX_START;
                tx_sub <= 4'h0;
                tx_cnt <= 4'h0;
            end
            else
            begin
                // A write with the upper lane enabled is the only way to carry the ninth bit
                if (wr_txd && !hold_valid)
                begin
                    hold_valid <= 1'b1;
                    hold_data <= {wr_lanes[1] & wdata[8], wdata[7:0]};
                end
                if (tick && tx_state != TX_IDLE)
                    tx_sub <= tx_sub + 4'h1;
                if (tx_bit_end)
                begin
                    tx_cnt <= tx_cnt + 4'h1;
                    case (tx_state)
                        TX_START:
                        begin
                            tx_state <= break_active ? TX_BRK : TX_DATA;
                            tx_cnt <= 4'h0;
                        end
                        TX_DATA:
                        begin
                            transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
                            if (tx_cnt == last_data)
                            begin
                                tx_state <= parity_on ? TX_PAR : TX_STOP;
                                tx_cnt <= 4'h0;
                            end
                        end
                        TX_PAR:
                        begin
                            tx_state <= TX_STOP;
                            tx_cnt <= 4'h0;
                        end
                        TX_BRK:
                        begin
                            if (tx_cnt == `BREAK_LAST)
                            begin
                                tx_state <= TX_STOP;
                                tx_cnt <= 4'h0;
                            end
                        end
                        TX_STOP:
                        begin
                            if (tx_finish)
                                tx_state <= TX_IDLE;
                        end
                        default:
                            tx_state <= TX_IDLE;
                    endcase
                end
            end
        end
    end

    // Line driver; the infrared form sends a short pulse for each zero bit
    reg line_bit;
    always @*
    begin
        case (tx_state)
            TX_START: line_bit = 1'b0;
            TX_DATA: line_bit = transmit_shift_register[0];
            TX_PAR: line_bit = tx_par;
            TX_BRK: line_bit = 1'b0;
            default: line_bit = 1'b1;
        endcase
    end

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serial_out_pin <= 1'b1;
            serial_out_enable <= 1'b0;
            tx_irq <= 1'b0;
        end
        else
        begin
            serial_out_enable <= transmitter_enable;
            if (!infrared_codec_enable)
                serial_out_pin <= line_bit;
            else if (!line_bit && tx_sub < `IR_PULSE)
                serial_out_pin <= !tx_encoded_polarity;
            else
                serial_out_pin <= tx_encoded_polarity;
            case (tx_mode)
                `TXI_EACH: tx_irq <= tx_load;
                `TXI_EMPTY: tx_irq <= tx_load && !wr_txd;
                `TXI_DONE: tx_irq <= tx_finish && !hold_valid;
                default: tx_irq <= 1'b0;
            endcase
        end
    end

    // Receiver: pin is synchronised before use, bits sampled at mid period
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_sync1 <= 1'b1;
            rx_in <= 1'b1;
            rx_state <= RX_IDLE;
            rx_sub <= 4'h0;
            rx_cnt <= 4'h0;
            receive_shift_register <= 9'h000;
            rx_par <= 1'b0;
            rx_parity_error_flag <= 1'b0;
        end
        else
        begin
            rx_sync1 <= serial_in_pin;
            rx_in <= rx_sync1;
            if (flush)
                rx_state <= RX_IDLE;
            else if (rx_state == RX_IDLE)
            begin
                if (!rx_in)
                begin
                    rx_state <= RX_START;
                    rx_sub <= 4'h0;
                end
            end
            else
            begin
                if (tick)
                    rx_sub <= rx_sub + 4'h1;
                if (rx_sample)
                begin
                    rx_cnt <= rx_cnt + 4'h1;
                    case (rx_state)
                        RX_START:
                        begin
                            rx_state <= rx_in ? RX_IDLE : RX_DATA;
                            rx_cnt <= 4'h0;
                        end
                        RX_DATA:
                        begin
                            receive_shift_register <= {rx_in, receive_shift_register[8:1]};
                            if (rx_cnt == last_data)
                                rx_state <= parity_on ? RX_PAR : RX_STOP;
                        end
                        RX_PAR:
                        begin
                            rx_par <= rx_in;
                            rx_state <= RX_STOP;
                        end
                        default:
                            rx_state <= RX_IDLE;
                    endcase
                end
            end
            if (rx_state == RX_STOP && parity_on)
                rx_parity_error_flag <= (rx_par != parity_expect);
            else if (rx_state == RX_STOP)
                rx_parity_error_flag <= 1'b0;
        end
    end

    // Receive FIFO bookkeeping, overrun and receive interrupt
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            overrun_error_flag <= 1'b0;
            rx_irq <= 1'b0;
        end
        else if (flush)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            overrun_error_flag <= 1'b0;
            rx_irq <= 1'b0;
        end
        else
        begin
            if (overflow)
                overrun_error_flag <= 1'b1;
            if (push)
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            rd_ptr <= next_rd_ptr;
            if (push && !pop)
                count <= count_after;
            else if (pop && !push)
                count <= count - {{AW{1'b0}}, 1'b1};
            case (rx_mode)
                `RXI_FULL: rx_irq <= push && !pop && count_after == DEPTH;
                `RXI_THREE: rx_irq <= push && !pop && count_after == `RX_THREE;
                default: rx_irq <= push;
            endcase
        end
    end

    // Read data stand for one cycle after the strobe; unmapped reads give zero
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 16'h0000;
        else if (!rd)
            rdata <= 16'h0000;
        else
        begin
            case (addr)
                `ADDR_MODE: rdata <= serial_mode_control;
                `ADDR_STAT: rdata <= {tx_irq_mode_hi, tx_encoded_polarity, tx_irq_mode_lo, 1'b0,
                    send_break_request, transmitter_enable, hold_valid, transmitter_empty,
                    rx_irq_mode_hi, rx_irq_mode_lo, address_detect_enable, receiver_idle_flag,
                    head[10] && count != 0, head[9] && count != 0, overrun_error_flag,
                    count != 0};
                `ADDR_RXD: rdata <= {7'h00, head[8:0]};
                `ADDR_BRG: rdata <= bit_rate_divisor;
                default: rdata <= 16'h0000;
            endcase
        end
    end
endmodule // uart_status_control_bank

// ---- verif/scb_chk.sv ----
// Port-level assertions for the serial control bank
`timescale 1ns/1ns
`include "uart_scb_regs.vh"
module scb_chk (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Register port
    input wire [15:0] addr,
    input wire [15:0] wdata,
    input wire [1:0] wr_lanes,
    input wire wr,
    input wire rd,
    input wire [15:0] rdata,
    // Serial pins and events
    input wire serial_in_pin,
    input wire serial_out_pin,
    input wire serial_out_enable,
    input wire tx_irq,
    input wire rx_irq
);
    reg ir_on;
    wire mapped = addr == `ADDR_MODE || addr == `ADDR_STAT || addr == `ADDR_TXD
        || addr == `ADDR_RXD || addr == `ADDR_BRG;
    // Encoded zero pulses are short, so the bit width check waits for the codec off
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            ir_on <= 1'b0;
        else if (wr && addr == `ADDR_MODE && wr_lanes[1])
            ir_on <= wdata[`MODE_IR_BIT];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence brg_wr_rd;
        wr && addr == `ADDR_BRG && wr_lanes == 2'b11 ##2 rd && addr == `ADDR_BRG;
    endsequence
    sequence mode_wr_rd;
        wr && addr == `ADDR_MODE && wr_lanes == 2'b11 ##2 rd && addr == `ADDR_MODE;
    endsequence
    rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
        else $error("rdata not idle");
    unmapped_read_a: assert property (rd && !mapped |=> rdata == 16'h0000)
        else $error("unmapped rdata");
    stat_rsvd_a: assert property (rd && addr == `ADDR_STAT |=> !rdata[12])
        else $error("status rsvd set");
    mode_rsvd_a: assert property (rd && addr == `ADDR_MODE |=> (rdata & 16'h4b00) == 16'h0000)
        else $error("mode rsvd set");
    brg_echo_a: assert property (brg_wr_rd |=> rdata == $past(wdata, 3))
        else $error("divisor echo");
    mode_echo_a: assert property (mode_wr_rd |=> rdata == ($past(wdata, 3) & `MODE_WMASK))
        else $error("mode echo");
    txirq_pulse_a: assert property (tx_irq |=> !tx_irq)
        else $error("long tx event");
    rxirq_pulse_a: assert property (rx_irq |=> !rx_irq)
        else $error("long rx event");
    pin_own_a: assert property (wr && addr == `ADDR_STAT && wr_lanes[1] |=> ##1
        serial_out_enable == $past(wdata[`STAT_TXEN], 2))
        else $error("pin owner wrong");
    bit_min_a: assert property ($fell(serial_out_pin) && !ir_on |-> !serial_out_pin [*8])
        else $error("short low bit");
endmodule // scb_chk

// ---- verif/line_partner.sv ----
// Remote serial transceiver model on the far end of the line
`timescale 1ns/1ns
module line_partner #(
    parameter TICKS = 16
) (
    // Clock
    input wire core_clk,
    // Line from the bank
    input wire serial_out_pin,
    input wire serial_out_enable,
    // Line into the bank
    output reg serial_in_pin
);
    reg [7:0] rx_last, rx_prev, rx_bits;
    integer n_rx, run, low_max, i;
    initial
    begin
        serial_in_pin = 1'b1;
        n_rx = 0;
        run = 0;
        low_max = 0;
        rx_last = 8'h00;
        rx_prev = 8'h00;
    end
    // Low start, nb bits LSB first, then stop and one idle bit, both high
    task send_char(input [8:0] d, input integer nb);
        integer k;
        begin
            @(posedge core_clk);
            serial_in_pin <= 1'b0;
            repeat (TICKS) @(posedge core_clk);
            for (k = 0; k < nb; k = k + 1)
            begin
                serial_in_pin <= d[k];
                repeat (TICKS) @(posedge core_clk);
            end
            serial_in_pin <= 1'b1;
            repeat (2 * TICKS) @(posedge core_clk);
        end
    endtask
    // Frames starting while the pin is not owned are ignored
    always
    begin
        @(negedge serial_out_pin);
        if (serial_out_enable === 1'b1)
        begin
            repeat (TICKS / 2) @(posedge core_clk);
            for (i = 0; i < 8; i = i + 1)
            begin
                repeat (TICKS) @(posedge core_clk);
                rx_bits[i] = serial_out_pin;
            end
            repeat (TICKS) @(posedge core_clk);
            rx_prev = rx_last;
            rx_last = rx_bits;
            n_rx = n_rx + 1;
        end
    end
    always @(posedge core_clk)
    begin
        if (serial_out_pin === 1'b0)
            run = run + 1;
        else
        begin
            if (run > low_max)
                low_max = run;
            run = 0;
        end
    end
endmodule // line_partner

// ---- verif/uart_status_control_bank_tb.sv ----
// Register-level bench for the serial control bank with a line partner
`timescale 1ns/1ns
`include "uart_scb_regs.vh"
module uart_status_control_bank_tb;
    reg core_clk = 1'b0;
    reg rst_b = 1'b0;
    reg [15:0] addr = 16'h0000;
    reg [15:0] wdata = 16'h0000;
    reg [1:0] wr_lanes = 2'b00;
    reg wr = 1'b0, rd = 1'b0;
    wire [15:0] rdata;
    wire serial_in_pin, serial_out_pin, serial_out_enable, tx_irq, rx_irq;
    integer n_errors = 0;
    integer n_tests = 0;
    integer n_txi = 0, n_rxi = 0;
    integer base, nrx, m, j;
    reg [15:0] v;
    reg [47:0] txm = {16'h2400, 16'h8400, 16'h0400};
    reg [47:0] txe = {16'h0001, 16'h0002, 16'h0002};
    reg [63:0] rxm = {16'h00c0, 16'h0080, 16'h0040, 16'h0000};
    reg [63:0] rxe = {16'h0001, 16'h0001, 16'h0004, 16'h0004};
    uart_status_control_bank uart_status_control_bank_inst (.*);
    line_partner line_partner_inst (.core_clk(core_clk), .serial_out_pin(serial_out_pin),
        .serial_out_enable(serial_out_enable), .serial_in_pin(serial_in_pin));
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (tx_irq === 1'b1)
            n_txi = n_txi + 1;
        if (rx_irq === 1'b1)
            n_rxi = n_rxi + 1;
    end
    task wr_reg(input [15:0] a, input [15:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr_lanes <= 2'b11;
            wr <= 1'b1;
            @(posedge core_clk);
            wr <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task rd_reg(input [15:0] a, output [15:0] d);
        begin
            addr <= a;
            rd <= 1'b1;
            @(posedge core_clk);
            rd <= 1'b0;
            @(posedge core_clk);
            d = rdata;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rd_chk(input [15:0] a, input [15:0] exp);
        reg [15:0] d;
        begin
            rd_reg(a, d);
            chk(d, exp);
        end
    endtask
    // Slack lets the last stop bit and its event land
    task wait_txe;
        integer k;
        begin
            v = 16'h0000;
            for (k = 0; k < 600 && v[`STAT_TXEMPTY] !== 1'b1; k = k + 1)
                rd_reg(`ADDR_STAT, v);
            repeat (24) @(posedge core_clk);
        end
    endtask
    task wrap_up;
        begin
            if (n_errors == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial
    begin
        #200000;
        n_errors = n_errors + 1;
        wrap_up;
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        rd_chk(`ADDR_STAT, `STAT_RESET);
        rd_chk(`ADDR_MODE, `MODE_RESET);
        rd_chk(`ADDR_BRG, `BRG_RESET);
        rd_chk(`ADDR_RXD, 16'h0000);
        rd_chk(16'h0230, 16'h0000);
        wr_reg(`ADDR_BRG, 16'h1234);
        rd_chk(`ADDR_BRG, 16'h1234);
        wr_reg(`ADDR_BRG, 16'h0000);
        wr_reg(`ADDR_MODE, 16'hffff);
        rd_chk(`ADDR_MODE, `MODE_WMASK);
        wr_reg(`ADDR_MODE, 16'h0000);
        for (m = 0; m < 3; m = m + 1)
        begin
            base = n_txi;
            nrx = line_partner_inst.n_rx;
            wr_reg(`ADDR_STAT, txm[m*16 +: 16]);
            repeat (2) @(posedge core_clk);
            chk({15'h0000, serial_out_enable}, 16'h0001);
            wr_reg(`ADDR_TXD, 16'h00a5);
            repeat (4) @(posedge core_clk);
            wr_reg(`ADDR_TXD, 16'h003c);
            rd_chk(`ADDR_STAT, txm[m*16 +: 16] | 16'h0210);
            wait_txe;
            chk(16'(n_txi - base), txe[m*16 +: 16]);
            chk(16'(line_partner_inst.n_rx - nrx), 16'h0002);
            chk({8'h00, line_partner_inst.rx_prev}, 16'h00a5);
            chk({8'h00, line_partner_inst.rx_last}, 16'h003c);
        end
        wr_reg(`ADDR_STAT, 16'h0c00);
        wr_reg(`ADDR_TXD, 16'h0000);
        wait_txe;
        chk(16'(line_partner_inst.low_max), 16'h00d0);
        rd_chk(`ADDR_STAT, 16'h0510);
        wr_reg(`ADDR_TXD, 16'h00ff);
        repeat (12) @(posedge core_clk);
        wr_reg(`ADDR_TXD, 16'h0081);
        wr_reg(`ADDR_STAT, 16'h0000);
        rd_chk(`ADDR_STAT, 16'h0110);
        chk({15'h0000, serial_out_enable}, 16'h0000);
        wr_reg(`ADDR_MODE, 16'h0002);
        for (m = 0; m < 4; m = m + 1)
        begin
            base = n_rxi;
            wr_reg(`ADDR_STAT, rxm[m*16 +: 16]);
            for (j = 1; j < 6; j = j + 1)
            begin
                v = 16'(j * 17);
                line_partner_inst.send_char({^v[7:0] ^ (j == 2), v[7:0]}, 9);
            end
            chk(16'(n_rxi - base), rxe[m*16 +: 16]);
            rd_chk(`ADDR_STAT, rxm[m*16 +: 16] | 16'h0113);
            rd_chk(`ADDR_RXD, 16'h0011);
            rd_chk(`ADDR_STAT, rxm[m*16 +: 16] | 16'h011b);
            rd_chk(`ADDR_RXD, 16'h0022);
            wr_reg(`ADDR_STAT, rxm[m*16 +: 16]);
            rd_chk(`ADDR_STAT, rxm[m*16 +: 16] | 16'h0110);
        end
        wrap_up;
    end
endmodule // uart_status_control_bank_tb
bind uart_status_control_bank scb_chk scb_chk_inst (.*);
